/* ttm_pkg.sv */
// package for the thermal threshold monitor: register map, timing, carriers
package ttm_pkg;

    localparam int unsigned NUM_WARN      = 6;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 8;

    // register offsets
    localparam logic [3:0] REG_EVENT      = 4'h0;
    localparam logic [3:0] REG_SENSE      = 4'h1;
    localparam logic [3:0] REG_MASK       = 4'h2;
    localparam logic [3:0] REG_CTRL       = 4'h3;
    localparam logic [3:0] REG_STATUS     = 4'h4;

    // control fields
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_AON_BIT  = 1;
    // status fields
    localparam int unsigned STAT_PWR_BIT  = 0;
    localparam int unsigned STAT_SD_BIT   = 1;
    localparam int unsigned STAT_LOCK_BIT = 2;

    // reset values
    localparam logic [5:0] MASK_RST       = 6'h3f;
    localparam logic       EN_RST         = 1'b1;
    localparam logic       AON_RST        = 1'b1;

    // timing
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned DEBOUNCE_US   = 10;
    localparam int unsigned WINDOW_US     = 450;
    localparam int unsigned INTERVAL_US   = 3000;
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
    localparam int unsigned WINDOW_CYC    = WINDOW_US * CLK_MHZ;
    localparam int unsigned INTERVAL_CYC  = INTERVAL_US * CLK_MHZ;

    // hysteresis in degrees C for the warning levels and for shutdown
    localparam int unsigned WARN_HYS_C    = 5;
    localparam int unsigned SD_HYS_C      = 15;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ttm_bus_req_t;

    // centre-die comparator outputs from the analog side
    typedef struct packed {
        logic [NUM_WARN-1:0] warn_rise; // above warning level
        logic [NUM_WARN-1:0] warn_fall; // below level minus hysteresis
        logic                sd_rise;   // above shutdown level
        logic                sd_fall;   // below shutdown minus hysteresis
    } ttm_cmp_t;

    typedef enum logic [1:0] {
        MON_OFF,
        MON_ON,
        MON_SAMPLE_ON,
        MON_SAMPLE_OFF
    } ttm_mon_state_t;

endpackage

/* ttm_monitor.sv */
// thermal threshold monitor: debounce, flags, shutdown lockout, sampling
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - rising crossing sets latched event flag
// RULE2 - six warning levels, each event/sense/mask
// RULE3 - sense clears after 5 C fall
// RULE4 - shutdown at 165 C, lockout 15 C
// RULE5 - only centre sensor drives decisions
// RULE6 - enable bit turns monitor on or off
// RULE7 - run with always-on keeps monitor powered
// RULE8 - sampling: 450 us every 3 ms
// RULE9 - standby forces sampling while enabled
// RULE10 - 10 us debounce both directions
// RULE11 - unmasked set event drives irq low
// RULE12 - software clears event by writing one
module ttm_monitor
    import ttm_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned WINDOW_CYCLES   = WINDOW_CYC,
    parameter int unsigned INTERVAL_CYCLES = INTERVAL_CYC
)
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire ttm_pkg::ttm_bus_req_t bus_req_i,
    output logic [ttm_pkg::DATA_W-1:0] bus_rdata_o,
    input  wire ttm_pkg::ttm_cmp_t centre_cmp_i,
    input  wire logic              standby_i,
    output logic                   monitor_power_o,
    output logic                   thermal_shutdown_o,
    output logic                   restart_block_o,
    output logic                   host_irq_n_o
);
    import ttm_pkg::*;

    localparam int unsigned NCMP = 2 * NUM_WARN + 2;
    localparam int unsigned CW   = 20;

    function automatic logic [CW-1:0] to_cnt(input int unsigned v);
        to_cnt = v[CW-1:0];
    endfunction

    // comparator synchronisers (analog domain)
    logic [NCMP-1:0] cmp_raw;
    logic [NCMP-1:0] sync1_q;
    logic [NCMP-1:0] sync2_q;
    assign cmp_raw = {centre_cmp_i.sd_fall, centre_cmp_i.sd_rise,
                      centre_cmp_i.warn_fall, centre_cmp_i.warn_rise}; // [RULE5]

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= cmp_raw;
            sync2_q <= sync1_q;
        end
    end

    // debounce: a change must hold for the full time, either direction
    logic [NCMP-1:0] deb_q;
    logic [CW-1:0]   deb_cnt_q [NCMP];
    logic            sampling_valid;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            deb_q <= '0;
            for (int i = 0; i < NCMP; i++)
                deb_cnt_q[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NCMP; i++)
            begin
                if (!sampling_valid || sync2_q[i] == deb_q[i])
                    deb_cnt_q[i] <= '0;
                else if (deb_cnt_q[i] >= to_cnt(DEBOUNCE_CYCLES - 1))
                begin
                    deb_q[i]     <= sync2_q[i];                // [RULE10]
                    deb_cnt_q[i] <= '0;
                end
                else
                    deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
            end
        end
    end

    logic [NUM_WARN-1:0] warn_rise;
    logic [NUM_WARN-1:0] warn_fall;
    logic                sd_rise;
    logic                sd_fall;
    assign warn_rise = deb_q[NUM_WARN-1:0];
    assign warn_fall = deb_q[2*NUM_WARN-1:NUM_WARN];
    assign sd_rise   = deb_q[2*NUM_WARN];
    assign sd_fall   = deb_q[2*NUM_WARN+1];

    // register bus
    logic                ctrl_en_q;
    logic                ctrl_aon_q;
    logic [NUM_WARN-1:0] mask_q;
    logic [NUM_WARN-1:0] sense_q;
    logic [NUM_WARN-1:0] event_q;
    logic                sd_q;
    logic                lock_q;
    logic                wr_event;
    assign wr_event = bus_req_i.wr && bus_req_i.addr == REG_EVENT;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_en_q  <= EN_RST;
            ctrl_aon_q <= AON_RST;
            mask_q     <= MASK_RST;
        end
        else if (bus_req_i.wr)
        begin
            case (bus_req_i.addr)
                REG_MASK: mask_q <= bus_req_i.wdata[NUM_WARN-1:0];
                REG_CTRL:
                begin
                    ctrl_en_q  <= bus_req_i.wdata[CTRL_EN_BIT];   // [RULE6]
                    ctrl_aon_q <= bus_req_i.wdata[CTRL_AON_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bus_rdata_o <= '0;
        else if (bus_req_i.rd)
        begin
            case (bus_req_i.addr)
                REG_EVENT:  bus_rdata_o <= DATA_W'(event_q);
                REG_SENSE:  bus_rdata_o <= DATA_W'(sense_q);
                REG_MASK:   bus_rdata_o <= DATA_W'(mask_q);
                REG_CTRL:   bus_rdata_o <= DATA_W'({ctrl_aon_q, ctrl_en_q});
                REG_STATUS: bus_rdata_o <= DATA_W'({lock_q, sd_q, monitor_power_o});
                default:    bus_rdata_o <= '0;
            endcase
        end
        else
            bus_rdata_o <= '0;
    end

    // sense flags with release hysteresis; events latch on rising edge
    logic [NUM_WARN-1:0] sense_set;
    assign sense_set = warn_rise & ~sense_q;                      // [RULE1]

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sense_q <= '0;
        else if (!ctrl_en_q)
            sense_q <= '0;
        else
            sense_q <= (sense_q | warn_rise) & ~(warn_fall & ~warn_rise); // [RULE3]
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            event_q <= '0;
        else
        begin
            // set wins over a same-cycle clear
            event_q <= (event_q & ~({NUM_WARN{wr_event}} & bus_req_i.wdata[NUM_WARN-1:0]))
                       | (sense_set & {NUM_WARN{ctrl_en_q}});     // [RULE1] [RULE2] [RULE12]
        end
    end

    // shutdown with restart lockout until cooled by the hysteresis
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sd_q   <= 1'b0;
            lock_q <= 1'b0;
        end
        else if (ctrl_en_q && sd_rise)
        begin
            sd_q   <= 1'b1;                                        // [RULE4]
            lock_q <= 1'b1;
        end
        else if (lock_q && sd_fall)
        begin
            sd_q   <= 1'b0;
            lock_q <= 1'b0;                                        // [RULE4]
        end
    end

    // power sequencing
    ttm_mon_state_t mon_state_q;
    logic [CW-1:0]  mon_cnt_q;
    logic           want_aon;
    assign want_aon = ctrl_aon_q && !standby_i;                   // [RULE7] [RULE9]

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mon_state_q <= MON_OFF;
            mon_cnt_q   <= '0;
        end
        else if (!ctrl_en_q)
        begin
            mon_state_q <= MON_OFF;                                // [RULE6]
            mon_cnt_q   <= '0;
        end
        else
        begin
            case (mon_state_q)
                MON_OFF, MON_ON:
                begin
                    mon_cnt_q   <= '0;
                    mon_state_q <= want_aon ? MON_ON : MON_SAMPLE_ON;
                end
                MON_SAMPLE_ON, MON_SAMPLE_OFF:
                begin
                    if (want_aon)
                    begin
                        mon_state_q <= MON_ON;
                        mon_cnt_q   <= '0;
                    end
                    else if (mon_cnt_q >= to_cnt(INTERVAL_CYCLES - 1))
                    begin
                        mon_state_q <= MON_SAMPLE_ON;              // [RULE8]
                        mon_cnt_q   <= '0;
                    end
                    else
                    begin
                        mon_cnt_q <= mon_cnt_q + 1'b1;
                        if (mon_cnt_q >= to_cnt(WINDOW_CYCLES - 1))
                            mon_state_q <= MON_SAMPLE_OFF;         // [RULE8]
                    end
                end
                default:
                begin
                    mon_state_q <= MON_OFF;
                    mon_cnt_q   <= '0;
                end
            endcase
        end
    end

    // comparators only trusted while powered; stale results hold
    assign sampling_valid = monitor_power_o;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            monitor_power_o    <= 1'b0;
            thermal_shutdown_o <= 1'b0;
            restart_block_o    <= 1'b0;
            host_irq_n_o       <= 1'b1;
        end
        else
        begin
            monitor_power_o    <= mon_state_q == MON_ON || mon_state_q == MON_SAMPLE_ON;
            thermal_shutdown_o <= sd_q;
            restart_block_o    <= lock_q;
            host_irq_n_o       <= ~|(event_q & ~mask_q);          // [RULE11]
        end
    end

endmodule

/* ttm_monitor_checker.sv */
// port checker for the thermal threshold monitor
`timescale 1ns/10ps
module ttm_monitor_checker
    import ttm_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = WINDOW_CYC
)
(
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    input  wire ttm_pkg::ttm_bus_req_t      bus_req_i,
    input  wire logic [ttm_pkg::DATA_W-1:0] bus_rdata_o,
    input  wire ttm_pkg::ttm_cmp_t          centre_cmp_i,
    input  wire logic                       standby_i,
    input  wire logic                       monitor_power_o,
    input  wire logic                       thermal_shutdown_o,
    input  wire logic                       restart_block_o,
    input  wire logic                       host_irq_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    int unsigned run_q;
    // slack of two covers a window that restarts on entry to standby
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            run_q <= 0;
        else if (!standby_i || !monitor_power_o)
            run_q <= 0;
        else
            run_q <= run_q + 1;
    end
    sequence s_ctrl_off;
        bus_req_i.wr && bus_req_i.addr == REG_CTRL && !bus_req_i.wdata[CTRL_EN_BIT];
    endsequence
    sequence s_mask_all;
        bus_req_i.wr && bus_req_i.addr == REG_MASK && bus_req_i.wdata[5:0] == 6'h3f;
    endsequence
    chk_rdata_idle: assert property (
        !$past(bus_req_i.rd) |-> bus_rdata_o == 8'h00) else $error("read data not idle");
    chk_unmapped_zero: assert property (
        bus_req_i.rd && bus_req_i.addr > REG_STATUS |=> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_block_tracks: assert property (
        restart_block_o == thermal_shutdown_o) else $error("lockout differs from shutdown");
    chk_sd_debounced: assert property (
        $rose(thermal_shutdown_o) |-> $past(centre_cmp_i.sd_rise, 5))
        else $error("shutdown without held crossing");
    chk_sd_release: assert property (
        $fell(thermal_shutdown_o) |-> $past(centre_cmp_i.sd_fall, 5))
        else $error("shutdown released before cooling");
    chk_off_power: assert property (
        s_ctrl_off |-> ##[1:3] !monitor_power_o) else $error("monitor powered while off");
    chk_irq_masked: assert property (
        s_mask_all |-> ##2 host_irq_n_o) else $error("interrupt while all masked");
    chk_standby_window: assert property (
        run_q <= WINDOW_CYCLES + 2) else $error("standby on-time too long");
endmodule

bind ttm_monitor ttm_monitor_checker #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .centre_cmp_i(centre_cmp_i), .standby_i(standby_i),
    .monitor_power_o(monitor_power_o), .thermal_shutdown_o(thermal_shutdown_o),
    .restart_block_o(restart_block_o), .host_irq_n_o(host_irq_n_o));

/* tb_thermal_threshold_monitor.sv */
// self-checking bench for the thermal threshold monitor
`timescale 1ns/10ps
module tb_thermal_threshold_monitor;
    import ttm_pkg::*;
    localparam int unsigned WIN = 20;
    localparam int unsigned PER = 100;
    logic         ref_clk_i;
    logic         rst_n_i;
    ttm_bus_req_t req;
    ttm_cmp_t     cmp;
    logic         stby;
    logic [7:0]   rdata;
    logic         pwr;
    logic         sd;
    logic         blk;
    logic         irq_n;
    int           mismatches;
    int           checked;
    int           seed;
    int           n;
    logic [7:0]   ev;
    logic [7:0]   msk;

    ttm_monitor #(.DEBOUNCE_CYCLES(4), .WINDOW_CYCLES(WIN), .INTERVAL_CYCLES(PER)) uut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(req), .bus_rdata_o(rdata),
        .centre_cmp_i(cmp), .standby_i(stby), .monitor_power_o(pwr),
        .thermal_shutdown_o(sd), .restart_block_o(blk), .host_irq_n_o(irq_n));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic exp_irq(input logic [7:0] e, input logic [7:0] m);
        return ~|(e[5:0] & ~m[5:0]);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // power-high cycles over one full period
    task automatic duty(input int e);
        n = 0;
        tick(PER);
        repeat (PER)
        begin
            @(posedge ref_clk_i);
            #1 n += pwr;
        end
        chk(n[7:0], e[7:0]);
    endtask
    task automatic summarize;
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        summarize();
    end

    initial
    begin
        seed = 32'h7cc08ffa;
        mismatches = 0;
        checked = 0;
        ev = 8'h00;
        rst_n_i = 1'b0;
        req = '0;
        stby = 1'b0;
        cmp = '{warn_rise: 6'h00, warn_fall: 6'h3f, sd_rise: 1'b0, sd_fall: 1'b1};
        tick(8);
        rst_n_i <= 1'b1;
        rd(REG_MASK, 8'h3f);
        rd(REG_CTRL, 8'h03);
        for (int a = 5; a < 16; a++)
            rd(a[3:0], 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            // short pulse must be swallowed
            cmp.warn_rise[k] <= 1'b1;
            tick(1 + ($unsigned($random(seed)) % 2));
            cmp.warn_rise[k] <= 1'b0;
            tick(12);
            rd(REG_EVENT, 8'h00);
        end
        for (int k = 0; k < 6; k++)
        begin
            cmp.warn_fall[k] <= 1'b0;
            cmp.warn_rise[k] <= 1'b1;
            tick(12);
            ev[k] = 1'b1;
            rd(REG_EVENT, ev);
            rd(REG_SENSE, ev);
            chkb(irq_n, 1'b1);
        end
        for (int i = 0; i < 5; i++)
        begin
            msk = (i == 4) ? 8'h00 : (8'($random(seed)) & 8'h3f);
            wr(REG_MASK, msk);
            tick(2);
            chkb(irq_n, exp_irq(ev, msk));
        end
        wr(REG_EVENT, 8'h05);
        rd(REG_EVENT, 8'h3a);
        // mask still open here, so only the clear can raise the line
        wr(REG_EVENT, 8'h3f);
        tick(2);
        chkb(irq_n, 1'b1);
        wr(REG_MASK, 8'h3f);
        cmp.warn_rise <= 6'h00;
        tick(12);
        rd(REG_SENSE, 8'h3f);
        cmp.warn_fall <= 6'h3f;
        tick(12);
        rd(REG_SENSE, 8'h00);
        wr(REG_MASK, 8'h00);
        cmp.warn_fall[0] <= 1'b0;
        cmp.warn_rise[0] <= 1'b1;
        tick(12);
        chkb(irq_n, 1'b0);
        cmp.sd_fall <= 1'b0;
        cmp.sd_rise <= 1'b1;
        tick(12);
        chk({6'h00, sd, blk}, 8'h03);
        rd(REG_STATUS, 8'h07);
        cmp.sd_rise <= 1'b0;
        tick(12);
        chk({6'h00, sd, blk}, 8'h03);
        cmp.sd_fall <= 1'b1;
        tick(12);
        chk({6'h00, sd, blk}, 8'h00);
        rd(REG_STATUS, 8'h01);
        cmp <= '{warn_rise: 6'h00, warn_fall: 6'h3f, sd_rise: 1'b0, sd_fall: 1'b1};
        wr(REG_EVENT, 8'h3f);
        wr(REG_CTRL, 8'h00);
        tick(4);
        chkb(pwr, 1'b0);
        cmp.warn_fall[1] <= 1'b0;
        cmp.warn_rise[1] <= 1'b1;
        tick(12);
        rd(REG_EVENT, 8'h00);
        cmp.warn_rise[1] <= 1'b0;
        cmp.warn_fall[1] <= 1'b1;
        wr(REG_CTRL, 8'h01);
        rd(REG_CTRL, 8'h01);
        duty(WIN);
        wr(REG_CTRL, 8'h03);
        stby <= 1'b1;
        duty(WIN);
        stby <= 1'b0;
        duty(PER);
        summarize();
    end
endmodule
